// file: src/spp_pkg.sv
// Purpose: Shared constants and types for the second serial port
// Assumes: Byte-wide register port, one system clock
// Notes: Register addresses are the printed byte offsets
package spp_pkg;
  // Register addresses
  localparam logic [7:0] SPP_ADDR_SADR = 8'hAA;
  localparam logic [7:0] SPP_ADDR_MASK = 8'hBA;
  localparam logic [7:0] SPP_ADDR_SCON = 8'hC0;
  localparam logic [7:0] SPP_ADDR_DBUF = 8'hC1;
  localparam logic [7:0] SPP_ADDR_CTRL = 8'hD0;
  localparam logic [7:0] SPP_ADDR_STAT = 8'hD1;
  // Serial control field positions
  localparam int SPP_SC_MODE_HI = 7;
  localparam int SPP_SC_MODE_LO = 6;
  localparam int SPP_SC_MPROC = 5;
  localparam int SPP_SC_REN = 4;
  localparam int SPP_SC_TB8 = 3;
  localparam int SPP_SC_RB8 = 2;
  localparam int SPP_SC_TI = 1;
  localparam int SPP_SC_RI = 0;
  // Control register field positions
  localparam int SPP_CT_IEN = 0;
  localparam int SPP_CT_GIE = 1;
  localparam int SPP_CT_PRI = 2;
  localparam int SPP_CT_FSEL = 3;
  localparam int SPP_CT_M2FAST = 4;
  // Status register field positions
  localparam int SPP_ST_TXA = 0;
  localparam int SPP_ST_RXA = 1;
  // Values after reset
  localparam logic [7:0] SPP_RST_BYTE = 8'h00;
  // Cycle counts
  localparam int SPP_SYNC_DIV_SLOW = 12;
  localparam int SPP_SYNC_DIV_FAST = 4;
  localparam int SPP_OS_RATE = 16;
  localparam int SPP_OS_MID = 7;
  localparam int SPP_M2_DIV_SLOW = 64 / SPP_OS_RATE;
  localparam int SPP_M2_DIV_FAST = 32 / SPP_OS_RATE;
  localparam int SPP_M0_BITS = 8;
  // Port modes and line states
  typedef enum logic [1:0] {SPP_M0, SPP_M1, SPP_M2, SPP_M3} spp_mode_e;
  typedef enum logic {SPP_IDLE, SPP_RUN} spp_state_e;
  // Register port request
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } spp_bus_s;
endpackage

// file: src/spp_tick_gen.sv
// Purpose: Bit and oversample ticks for the serial port
// Assumes: baud_tick is a one-cycle pulse at sixteen times the bit rate
// Notes: restart aligns the synchronous shift clock to a new byte
`timescale 1ns/10ps
module spp_tick_gen (
  input wire logic mclk,
  input wire logic rst,
  input wire logic restart,
  input spp_pkg::spp_mode_e mode,
  input wire logic sync_fast,
  input wire logic m2_fast,
  input wire logic baud_tick,
  output logic sync_tick,
  output logic sync_half,
  output logic os_tick
);
  import spp_pkg::*;
  logic [3:0] cnt_reg;
  logic [3:0] cnt_next;
  logic [3:0] div;

  // Divider select and next count
  always_comb begin
    if (mode == SPP_M0) begin
      div = sync_fast ? 4'(SPP_SYNC_DIV_FAST) : 4'(SPP_SYNC_DIV_SLOW);
    end else begin
      div = m2_fast ? 4'(SPP_M2_DIV_FAST) : 4'(SPP_M2_DIV_SLOW);
    end
    cnt_next = cnt_reg + 4'h1;
    if (restart || cnt_reg >= div - 4'h1) begin
      cnt_next = 4'h0;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      cnt_reg <= 4'h0;
    end else begin
      cnt_reg <= cnt_next;
    end
  end

  // Tick decode per mode
  assign sync_tick = (mode == SPP_M0) && (cnt_reg == div - 4'h1);
  assign sync_half = (mode == SPP_M0) && (cnt_reg == (div >> 1) - 4'h1);
  assign os_tick = (mode == SPP_M2) ? (cnt_reg == div - 4'h1) :
                   (mode != SPP_M0) && baud_tick;
endmodule

// file: src/spp_serial_port.sv
// Purpose: Second serial port with multiprocessor address matching
// Assumes: baud_tick comes from a timer on mclk; pins are asynchronous
// Notes: Receive pin is two-way since it carries data in shift mode
// Summary of operation
// - Two mode bits pick shift mode or 10-bit or 11-bit async frames
// - Top control bit is mode bit or sticky framing-error flag
// - 11-bit modes with multiprocessor on skip frames with ninth bit 0
// - 10-bit mode with multiprocessor on skips frames with bad stop
// - Shift mode clock is divide by 12, or by 4 with multiprocessor
// - Reception starts only while the receive enable is set
// - 11-bit modes send the software ninth bit; hardware never alters
// - Received ninth field holds ninth bit, or stop bit in mode 1 with multiprocessor off
// - Transmit flag sets after bit 8 or at stop start; software clears
// - Receive flag sets after bit 8 or mid stop; software clears
// - Data buffer reads give received byte, writes load transmit byte only while both directions are idle
// - Mask bits of one compare address bits, zeros are ignored
// - All-zero mask accepts any incoming address
// - Interrupt needs both port enable and global enable
// - Priority bit one selects high level, zero low level
// - Receive and transmit sit on port 1 bits 2 and 3
// - Activity bits run during transfer, receive only in async modes; transmit clears when its flag sets, receive at frame end
//
// The implementer's own choice: the address-and-strobe port.
`timescale 1ns/10ps
module spp_serial_port (
  input wire logic mclk,
  input wire logic rst,
  input spp_pkg::spp_bus_s bus,
  output logic [7:0] rdata,
  input wire logic baud_tick,
  input wire logic rx_pin_in,
  output logic rx_pin_out,
  output logic rx_pin_oe_n,
  output logic tx_pin_out,
  output logic irq_high,
  output logic irq_low
);
  import spp_pkg::*;
  // Control register state
  logic [7:0] sadr_reg, sadr_next, mask_reg, mask_next;
  logic [7:0] rxd_reg, rxd_next, ctrl_reg, ctrl_next, rdata_next;
  logic sm0_reg, sm0_next, sm1_reg, sm1_next, mp_reg, mp_next;
  logic ren_reg, ren_next, tb8_reg, tb8_next, rb8_reg, rb8_next;
  logic ti_reg, ti_next, ri_reg, ri_next, fe_reg, fe_next;
  logic txa_reg, txa_next, rxa_reg, rxa_next;
  logic irqh_next, irql_next, req;
  // Transmit state
  spp_state_e tx_st_reg, tx_st_next;
  logic [10:0] tx_sh_reg, tx_sh_next;
  logic [3:0] tx_cnt_reg, tx_cnt_next, tx_ph_reg, tx_ph_next;
  logic sclk_reg, sclk_next, txo_next, rxo_next, rxoe_next;
  // Receive state
  spp_state_e rx_st_reg, rx_st_next;
  logic [8:0] rx_sh_reg, rx_sh_next;
  logic [3:0] rx_cnt_reg, rx_cnt_next, rx_ph_reg, rx_ph_next;
  logic rx_s1, rx_s2, rx_s3;
  // Events between groups
  spp_mode_e mode;
  logic wr_scon, wr_dbuf, ti_set, ri_set, fe_set, rx_done, rx_start;
  logic tx_start, restart, sync_tick, sync_half, os_tick;
  logic [7:0] rx_byte;
  logic rx_ninth, stop_ok, addr_ok;

  assign mode = spp_mode_e'({sm0_reg, sm1_reg});
  assign wr_scon = bus.wr && bus.addr == SPP_ADDR_SCON;
  assign wr_dbuf = bus.wr && bus.addr == SPP_ADDR_DBUF;

  // Tick source for both directions
  spp_tick_gen u_tick (
    .mclk(mclk),
    .rst(rst),
    .restart(restart),
    .mode(mode),
    .sync_fast(mp_reg),
    .m2_fast(ctrl_reg[SPP_CT_M2FAST]),
    .baud_tick(baud_tick),
    .sync_tick(sync_tick),
    .sync_half(sync_half),
    .os_tick(os_tick)
  );

  // Receive pin synchroniser, port 1 bit 2
  always_ff @(posedge mclk) begin
    if (rst) begin
      rx_s1 <= 1'b1;
      rx_s2 <= 1'b1;
      rx_s3 <= 1'b1;
    end else begin
      rx_s1 <= rx_pin_in;
      rx_s2 <= rx_s1;
      rx_s3 <= rx_s2;
    end
  end

  // Transmitter next state
  always_comb begin
    tx_st_next = tx_st_reg;
    tx_sh_next = tx_sh_reg;
    tx_cnt_next = tx_cnt_reg;
    tx_ph_next = tx_ph_reg;
    ti_set = 1'b0;
    tx_start = wr_dbuf && tx_st_reg == SPP_IDLE && rx_st_reg == SPP_IDLE;
    if (tx_start) begin
      tx_st_next = SPP_RUN;
      tx_ph_next = 4'h0;
      case (mode)
        SPP_M0: begin
          tx_sh_next = {3'b111, bus.wdata};
          tx_cnt_next = 4'(SPP_M0_BITS);
        end
        SPP_M1: begin
          tx_sh_next = {2'b11, bus.wdata, 1'b0};
          tx_cnt_next = 4'h9;
        end
        default: begin
          tx_sh_next = {1'b1, tb8_reg, bus.wdata, 1'b0};
          tx_cnt_next = 4'hA;
        end
      endcase
    end else if (tx_st_reg == SPP_RUN) begin
      if (mode == SPP_M0) begin
        if (sync_tick) begin
          tx_sh_next = {1'b1, tx_sh_reg[10:1]};
          tx_cnt_next = tx_cnt_reg - 4'h1;
          if (tx_cnt_reg == 4'h1) begin
            ti_set = 1'b1;
            tx_st_next = SPP_IDLE;
          end
        end
      end else if (os_tick) begin
        tx_ph_next = tx_ph_reg + 4'h1;
        if (tx_ph_reg == 4'(SPP_OS_RATE - 1)) begin
          tx_sh_next = {1'b1, tx_sh_reg[10:1]};
          if (tx_cnt_reg == 4'h0) begin
            tx_st_next = SPP_IDLE;
          end else begin
            tx_cnt_next = tx_cnt_reg - 4'h1;
            ti_set = tx_cnt_reg == 4'h1;
          end
        end
      end
    end
  end

  // Receiver next state
  always_comb begin
    rx_st_next = rx_st_reg;
    rx_sh_next = rx_sh_reg;
    rx_cnt_next = rx_cnt_reg;
    rx_ph_next = rx_ph_reg;
    rx_done = 1'b0;
    rx_start = 1'b0;
    restart = tx_start && mode == SPP_M0;
    if (rx_st_reg == SPP_IDLE) begin
      if (mode == SPP_M0) begin
        rx_start = ren_reg && !ri_reg && tx_st_reg == SPP_IDLE;
        restart = restart || rx_start;
      end else begin
        rx_start = ren_reg && !rx_s2 && rx_s3;
      end
      if (rx_start) begin
        rx_st_next = SPP_RUN;
        rx_cnt_next = 4'h0;
        rx_ph_next = 4'h0;
      end
    end else if (mode == SPP_M0) begin
      if (sync_half) begin
        rx_sh_next = {rx_s2, rx_sh_reg[8:1]};
        rx_cnt_next = rx_cnt_reg + 4'h1;
      end
      if (sync_tick && rx_cnt_reg == 4'(SPP_M0_BITS)) begin
        rx_done = 1'b1;
        rx_st_next = SPP_IDLE;
      end
    end else if (os_tick) begin
      rx_ph_next = rx_ph_reg + 4'h1;
      if (rx_ph_reg == 4'(SPP_OS_MID)) begin
        rx_cnt_next = rx_cnt_reg + 4'h1;
        if (rx_cnt_reg == 4'h0) begin
          if (rx_s2) begin
            rx_st_next = SPP_IDLE;
          end
        end else if (rx_cnt_reg == (mode == SPP_M1 ? 4'h9 : 4'hA)) begin
          rx_done = 1'b1;
          rx_st_next = SPP_IDLE;
        end else begin
          rx_sh_next = {rx_s2, rx_sh_reg[8:1]};
        end
      end
    end
  end

  // Received frame contents and acceptance
  always_comb begin
    rx_byte = (mode == SPP_M2 || mode == SPP_M3) ? rx_sh_reg[7:0] :
              rx_sh_reg[8:1];
    rx_ninth = rx_sh_reg[8];
    stop_ok = rx_s2;
    addr_ok = ((rx_byte ^ sadr_reg) & mask_reg) == 8'h00;
    ri_set = 1'b0;
    fe_set = rx_done && mode != SPP_M0 && !stop_ok && ctrl_reg[SPP_CT_FSEL];
    if (rx_done && !ri_reg) begin
      case (mode)
        SPP_M0: ri_set = 1'b1;
        SPP_M1: ri_set = !mp_reg || stop_ok;
        default: ri_set = !mp_reg || (rx_ninth && addr_ok);
      endcase
    end
  end

  // Register file next values
  always_comb begin
    sadr_next = sadr_reg;
    mask_next = mask_reg;
    ctrl_next = ctrl_reg;
    sm0_next = sm0_reg;
    sm1_next = sm1_reg;
    mp_next = mp_reg;
    ren_next = ren_reg;
    tb8_next = tb8_reg;
    rb8_next = rb8_reg;
    ti_next = ti_reg;
    ri_next = ri_reg;
    fe_next = fe_reg;
    rxd_next = rxd_reg;
    txa_next = txa_reg;
    rxa_next = rxa_reg;
    if (bus.wr) begin
      case (bus.addr)
        SPP_ADDR_SADR: sadr_next = bus.wdata;
        SPP_ADDR_MASK: mask_next = bus.wdata;
        SPP_ADDR_CTRL: ctrl_next = bus.wdata;
        SPP_ADDR_SCON: begin
          if (ctrl_reg[SPP_CT_FSEL]) begin
            fe_next = bus.wdata[SPP_SC_MODE_HI];
          end else begin
            sm0_next = bus.wdata[SPP_SC_MODE_HI];
          end
          sm1_next = bus.wdata[SPP_SC_MODE_LO];
          mp_next = bus.wdata[SPP_SC_MPROC];
          ren_next = bus.wdata[SPP_SC_REN];
          tb8_next = bus.wdata[SPP_SC_TB8];
          rb8_next = bus.wdata[SPP_SC_RB8];
          ti_next = bus.wdata[SPP_SC_TI];
          ri_next = bus.wdata[SPP_SC_RI];
        end
        default: ;
      endcase
    end
    // Hardware sets win over software clears
    if (tx_start) begin
      txa_next = 1'b1;
    end
    if (ti_set) begin
      ti_next = 1'b1;
      txa_next = 1'b0;
    end
    if (rx_start && mode != SPP_M0) begin
      rxa_next = 1'b1;
    end
    if (rx_done) begin
      rxa_next = 1'b0;
    end
    if (fe_set) begin
      fe_next = 1'b1;
    end
    if (ri_set) begin
      ri_next = 1'b1;
      rxd_next = rx_byte;
      if (mode != SPP_M0 && (mode != SPP_M1 || !mp_reg)) begin
        rb8_next = mode == SPP_M1 ? stop_ok : rx_ninth;
      end
    end
    req = (ti_reg || ri_reg) && ctrl_reg[SPP_CT_IEN] &&
          ctrl_reg[SPP_CT_GIE];
    irqh_next = req && ctrl_reg[SPP_CT_PRI];
    irql_next = req && !ctrl_reg[SPP_CT_PRI];
    // Read data for the cycle after the strobe
    rdata_next = 8'h00;
    if (bus.rd) begin
      case (bus.addr)
        SPP_ADDR_SADR: rdata_next = sadr_reg;
        SPP_ADDR_MASK: rdata_next = mask_reg;
        SPP_ADDR_CTRL: rdata_next = ctrl_reg;
        SPP_ADDR_DBUF: rdata_next = rxd_reg;
        SPP_ADDR_STAT: rdata_next = {6'h00, rxa_reg, txa_reg};
        SPP_ADDR_SCON: rdata_next = {
          ctrl_reg[SPP_CT_FSEL] ? fe_reg : sm0_reg, sm1_reg, mp_reg,
          ren_reg, tb8_reg, rb8_reg, ti_reg, ri_reg};
        default: rdata_next = 8'h00;
      endcase
    end
  end

  // Pin output next values, port 1 bit 3 and bit 2
  always_comb begin
    sclk_next = sclk_reg;
    if (mode == SPP_M0 && (tx_st_next == SPP_RUN || rx_st_next == SPP_RUN))
    begin
      if (restart || sync_tick) begin
        sclk_next = 1'b0;
      end else if (sync_half) begin
        sclk_next = 1'b1;
      end
    end else begin
      sclk_next = 1'b1;
    end
    rxoe_next = !(mode == SPP_M0 && tx_st_next == SPP_RUN);
    rxo_next = rxoe_next ? 1'b1 : tx_sh_next[0];
    if (mode == SPP_M0) begin
      txo_next = sclk_next;
    end else begin
      txo_next = tx_st_next == SPP_RUN ? tx_sh_next[0] : 1'b1;
    end
  end

  // State registers
  always_ff @(posedge mclk) begin
    if (rst) begin
      sadr_reg <= SPP_RST_BYTE;
      mask_reg <= SPP_RST_BYTE;
      ctrl_reg <= SPP_RST_BYTE;
      rxd_reg <= SPP_RST_BYTE;
      {sm0_reg, sm1_reg, mp_reg, ren_reg} <= 4'h0;
      {tb8_reg, rb8_reg, ti_reg, ri_reg} <= 4'h0;
      {fe_reg, txa_reg, rxa_reg, sclk_reg} <= 4'h1;
      tx_st_reg <= SPP_IDLE;
      rx_st_reg <= SPP_IDLE;
      tx_sh_reg <= 11'h7FF;
      rx_sh_reg <= 9'h000;
      {tx_cnt_reg, tx_ph_reg, rx_cnt_reg, rx_ph_reg} <= 16'h0000;
      rdata <= 8'h00;
      {irq_high, irq_low, rx_pin_out, rx_pin_oe_n, tx_pin_out} <= 5'h07;
    end else begin
      sadr_reg <= sadr_next;
      mask_reg <= mask_next;
      ctrl_reg <= ctrl_next;
      rxd_reg <= rxd_next;
      {sm0_reg, sm1_reg, mp_reg, ren_reg} <= {sm0_next, sm1_next, mp_next,
                                              ren_next};
      {tb8_reg, rb8_reg, ti_reg, ri_reg} <= {tb8_next, rb8_next, ti_next,
                                             ri_next};
      {fe_reg, txa_reg, rxa_reg, sclk_reg} <= {fe_next, txa_next, rxa_next,
                                               sclk_next};
      tx_st_reg <= tx_st_next;
      rx_st_reg <= rx_st_next;
      tx_sh_reg <= tx_sh_next;
      rx_sh_reg <= rx_sh_next;
      {tx_cnt_reg, tx_ph_reg} <= {tx_cnt_next, tx_ph_next};
      {rx_cnt_reg, rx_ph_reg} <= {rx_cnt_next, rx_ph_next};
      rdata <= rdata_next;
      {irq_high, irq_low} <= {irqh_next, irql_next};
      {rx_pin_out, rx_pin_oe_n, tx_pin_out} <= {rxo_next, rxoe_next,
                                                txo_next};
    end
  end

  // Checks on the serial port behaviour
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (rst);

  a_mode_decode: assert property (
    wr_scon && !ctrl_reg[SPP_CT_FSEL] |=> mode == $past(bus.wdata[7:6]))
    else $error("mode bits not decoded");
  a_fe_sticky: assert property (
    fe_reg && !wr_scon |=> fe_reg) else $error("framing flag lost");
  a_ninth_filter: assert property (
    rx_done && mode inside {SPP_M2, SPP_M3} && mp_reg && !rx_ninth
    && !ri_reg && !wr_scon |=> !ri_reg) else $error("ninth bit ignored");
  a_stop_filter: assert property (
    rx_done && mode == SPP_M1 && mp_reg && !stop_ok && !ri_reg
    && !wr_scon |=> !ri_reg) else $error("bad stop accepted");
  a_sync_rate: assert property (
    sync_tick && !restart |=> !sync_tick [*3])
    else $error("shift clock too fast");
  a_ren_gate: assert property (
    rx_st_reg == SPP_IDLE && !ren_reg |=> rx_st_reg == SPP_IDLE)
    else $error("receive while disabled");
  a_tb8_owner: assert property (
    tb8_reg != $past(tb8_reg) |-> $past(wr_scon))
    else $error("ninth tx bit changed by hardware");
  a_ti_hold: assert property (
    ti_reg && !wr_scon |=> ti_reg) else $error("transmit flag lost");
  a_ri_data: assert property (
    ri_set |=> ri_reg && rxd_reg == $past(rx_byte))
    else $error("receive byte not loaded");
  a_irq_gate: assert property (
    irq_high |-> $past(ctrl_reg[SPP_CT_GIE] && ctrl_reg[SPP_CT_IEN]
    && ctrl_reg[SPP_CT_PRI])) else $error("interrupt not gated");
  a_tx_activity: assert property (
    ti_set |=> !txa_reg && ti_reg) else $error("activity not cleared");
endmodule

// file: verification/spp_remote_node.sv
// Purpose: Remote serial node on the far side of the second serial port
// Assumes: Receive line idles high through a pull-up
// Notes: Bit time in clocks is handed in by the bench for each frame
`timescale 1ns/10ps
module spp_remote_node (
  input wire logic mclk,
  input wire logic tx_line,
  output logic rx_drive
);
  initial rx_drive = 1'b1;

  // Send start, eight data bits LSB first, optional ninth, then stop
  task automatic send(input int nbits, input logic [7:0] data,
                      input logic nine, input logic stop, input int bclk);
    logic [10:0] f;
    f = (nbits == 11) ? {stop, nine, data, 1'b0} : {1'b1, stop, data, 1'b0};
    for (int i = 0; i < nbits; i++) begin
      rx_drive <= f[i];
      repeat (bclk) @(posedge mclk);
    end
    rx_drive <= 1'b1; // Release to pull-up level
  endtask

  // Shift mode: put each bit out after the port's clock falls
  task automatic shift_in(input logic [7:0] data);
    for (int i = 0; i < 8; i++) begin
      while (tx_line !== 1'b0) @(posedge mclk);
      rx_drive <= data[i];
      while (tx_line !== 1'b1) @(posedge mclk);
    end
    rx_drive <= 1'b1; // Release to pull-up level
  endtask

  // Capture one frame from the port, sampling each bit at its centre
  task automatic capture(input int nbits, input int bclk,
                         output logic [10:0] bits, output logic ok);
    int n;
    bits = '0;
    n = 0;
    while (tx_line === 1'b1 && n < 4000) begin
      @(posedge mclk);
      n++;
    end
    ok = (n < 4000);
    repeat (bclk / 2) @(posedge mclk);
    bits[0] = tx_line;
    for (int i = 1; i < nbits; i++) begin
      repeat (bclk) @(posedge mclk);
      bits[i] = tx_line;
    end
  endtask
endmodule

// file: verification/second_serial_port_with_addr_match_tb.sv
// Purpose: Self-checking bench for the second serial port
// Assumes: Baud tick every second clock, so 32 clocks per bit in modes 1 and 3
// Notes: Scenarios share the port state and run in a fixed order
`timescale 1ns/10ps
module second_serial_port_with_addr_match_tb;
  import spp_pkg::*;
  localparam int BCLK = 32;
  logic mclk;
  logic rst;
  logic baud_tick;
  spp_bus_s bus;
  logic [7:0] rdata;
  logic rx_pin_out;
  logic rx_pin_oe_n;
  logic tx_pin_out;
  logic irq_high;
  logic irq_low;
  logic node_drv;
  wire rx_line = rx_pin_oe_n ? node_drv : rx_pin_out;
  int bad_count = 0;
  int n_tests = 0;
  int cyc = 0;

  spp_serial_port u_spp_serial_port (.mclk(mclk), .rst(rst), .bus(bus),
    .rdata(rdata), .baud_tick(baud_tick), .rx_pin_in(rx_line),
    .rx_pin_out(rx_pin_out), .rx_pin_oe_n(rx_pin_oe_n),
    .tx_pin_out(tx_pin_out), .irq_high(irq_high), .irq_low(irq_low));
  spp_remote_node u_spp_remote_node (.mclk(mclk), .tx_line(tx_pin_out),
    .rx_drive(node_drv));

  // Clock and baud tick
  initial begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end
  always @(posedge mclk) baud_tick <= rst ? 1'b0 : ~baud_tick;

  // Cut a hang short
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 30000) begin
      bad_count++;
      results();
    end
  end

  task automatic chk(input logic [7:0] got, input logic [7:0] exp,
                     input string what);
    n_tests++;
    if (got !== exp) begin
      bad_count++;
      $display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk);
    bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge mclk);
    bus <= '0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge mclk);
    bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge mclk);
    bus <= '0;
    @(negedge mclk);
    d = rdata;
  endtask

  // Reset values, idle pins, read-back and an unmapped place
  task automatic t_reset;
    logic [7:0] d;
    logic [7:0] av [7] = '{SPP_ADDR_SADR, SPP_ADDR_MASK, SPP_ADDR_SCON,
      SPP_ADDR_DBUF, SPP_ADDR_CTRL, SPP_ADDR_STAT, 8'h55};
    chk({4'h0, tx_pin_out, rx_pin_oe_n, irq_high, irq_low}, 8'h0C, "pins");
    for (int i = 0; i < 7; i++) begin
      rd(av[i], d);
      chk(d, SPP_RST_BYTE, "reset value");
    end
    wr(SPP_ADDR_SADR, 8'hC3);
    wr(8'h55, 8'hFF);
    rd(SPP_ADDR_SADR, d);
    chk(d, 8'hC3, "address read-back");
    rd(8'h55, d);
    chk(d, 8'h00, "unmapped read");
    $display("Done: reset");
  endtask

  // One frame in each async mode, ninth bit from software
  task automatic t_tx;
    logic [10:0] b;
    logic ok;
    logic [7:0] d;
    int nb;
    int bc;
    int mv;
    // Pass 4 repeats the fixed-rate mode at the doubled rate
    for (int m = 1; m < 5; m++) begin
      mv = (m == 4) ? 2 : m;
      nb = (mv == 1) ? 10 : 11;
      bc = (m == 2) ? 64 : BCLK;
      wr(SPP_ADDR_CTRL, (m == 4) ? 8'h13 : 8'h03);
      wr(SPP_ADDR_SCON, {2'(mv), 2'b00, mv[0], 3'b000});
      wr(SPP_ADDR_DBUF, 8'hA5 ^ 8'(m));
      rd(SPP_ADDR_STAT, d);
      chk(d, 8'h01, "tx busy");
      u_spp_remote_node.capture(nb, bc, b, ok);
      chk({7'h00, ok}, 8'h01, "frame start");
      chk(b[8:1], 8'hA5 ^ 8'(m), "tx data");
      chk({6'h00, b[nb - 1], b[0]}, 8'h02, "tx framing");
      chk({7'h00, b[9]}, (mv == 2) ? 8'h00 : 8'h01, "ninth");
      chk({7'h00, irq_low}, 8'h01, "tx flag at stop");
      rd(SPP_ADDR_SCON, d);
      chk(d, {2'(mv), 2'b00, mv[0], 3'b010}, "tx control");
      rd(SPP_ADDR_STAT, d);
      chk(d, 8'h00, "tx idle");
      // Let the stop bit finish; a buffer write during it is dropped
      repeat (bc) @(posedge mclk);
    end
    wr(SPP_ADDR_CTRL, 8'h00);
    $display("Done: transmit");
  endtask

  // Shift mode: clock rate, data on the receive pin, flag
  task automatic t_mode0;
    logic [7:0] got;
    logic [7:0] d;
    logic prev;
    int lowc;
    int rises;
    int n;
    for (int s = 0; s < 2; s++) begin
      wr(SPP_ADDR_SCON, {2'b00, 1'(s), 5'h00});
      wr(SPP_ADDR_DBUF, 8'h96);
      lowc = 0;
      rises = 0;
      n = 0;
      prev = 1'b1;
      got = 8'h00;
      while (rises < 8 && n < 400) begin
        @(posedge mclk);
        n++;
        if (tx_pin_out === 1'b0) lowc++;
        if (tx_pin_out === 1'b1 && prev === 1'b0) begin
          rises++;
          got = {rx_line, got[7:1]};
        end
        prev = tx_pin_out;
      end
      chk(got, 8'h96, "shift data");
      chk(8'(lowc), (s == 1) ? 8'h10 : 8'h30, "shift clock");
      repeat (8) @(posedge mclk);
      rd(SPP_ADDR_SCON, d);
      chk(d, {2'b00, 1'(s), 5'b00010}, "shift tx flag");
    end
    // Receive one byte clocked in from the node at the slow rate
    wr(SPP_ADDR_SCON, 8'h10);
    u_spp_remote_node.shift_in(8'h6B);
    repeat (16) @(posedge mclk);
    rd(SPP_ADDR_SCON, d);
    chk(d, 8'h11, "shift rx flag");
    rd(SPP_ADDR_DBUF, d);
    chk(d, 8'h6B, "shift rx data");
    $display("Done: shift mode");
  endtask

  // 10-bit reception, stop bit as ninth, interrupt gating
  task automatic t_rx;
    logic [7:0] d;
    logic [7:0] cv [4] = '{8'h01, 8'h02, 8'h03, 8'h07};
    logic [7:0] iv [4] = '{8'h00, 8'h00, 8'h01, 8'h02};
    wr(SPP_ADDR_SCON, 8'h50);
    u_spp_remote_node.send(10, 8'h3C, 1'b0, 1'b1, BCLK);
    rd(SPP_ADDR_SCON, d);
    chk(d, 8'h55, "rx control");
    rd(SPP_ADDR_DBUF, d);
    chk(d, 8'h3C, "rx data");
    for (int i = 0; i < 4; i++) begin
      wr(SPP_ADDR_CTRL, cv[i]);
      repeat (2) @(posedge mclk);
      #1;
      chk({6'h00, irq_high, irq_low}, iv[i], "irq");
    end
    wr(SPP_ADDR_CTRL, 8'h00);
    $display("Done: receive");
  endtask

  // Bad stop with multiprocessor on: no flag, framing flag kept
  task automatic t_frame;
    logic [7:0] d;
    wr(SPP_ADDR_SCON, 8'h70);
    wr(SPP_ADDR_CTRL, 8'h08);
    u_spp_remote_node.send(10, 8'hC3, 1'b0, 1'b0, BCLK);
    rd(SPP_ADDR_SCON, d);
    chk(d, 8'hF0, "framing flag");
    wr(SPP_ADDR_SCON, 8'h70);
    rd(SPP_ADDR_SCON, d);
    chk(d, 8'h70, "framing clear");
    wr(SPP_ADDR_CTRL, 8'h00);
    rd(SPP_ADDR_SCON, d);
    chk(d, 8'h70, "mode kept");
    $display("Done: framing");
  endtask

  // Receive enable off ignores a frame
  task automatic t_ren_off;
    logic [7:0] d;
    wr(SPP_ADDR_SCON, 8'h40);
    u_spp_remote_node.send(10, 8'h5A, 1'b0, 1'b1, BCLK);
    rd(SPP_ADDR_SCON, d);
    chk(d, 8'h40, "rx disabled");
    $display("Done: receive disabled");
  endtask

  // Ninth-bit and masked address filtering in 11-bit mode
  task automatic t_mproc;
    logic [7:0] d;
    logic [7:0] dv [4] = '{8'h53, 8'h53, 8'h63, 8'h99};
    logic nv [4] = '{1'b0, 1'b1, 1'b1, 1'b1};
    logic rv [4] = '{1'b0, 1'b1, 1'b0, 1'b1};
    wr(SPP_ADDR_SADR, 8'h5A);
    wr(SPP_ADDR_MASK, 8'hF0);
    for (int i = 0; i < 4; i++) begin
      if (i == 3) wr(SPP_ADDR_MASK, 8'h00);
      wr(SPP_ADDR_SCON, 8'hF0);
      u_spp_remote_node.send(11, dv[i], nv[i], 1'b1, BCLK);
      rd(SPP_ADDR_SCON, d);
      chk(d, rv[i] ? 8'hF5 : 8'hF0, "filter");
      if (rv[i]) begin
        rd(SPP_ADDR_DBUF, d);
        chk(d, dv[i], "filtered data");
      end
    end
    $display("Done: address filter");
  endtask

  task automatic results;
    $display("Comparisons %0d, mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // Main sequence
  initial begin
    rst = 1'b1;
    bus = '0;
    repeat (6) @(posedge mclk);
    rst <= 1'b0;
    t_reset();
    t_tx();
    t_mode0();
    t_rx();
    t_frame();
    t_ren_off();
    t_mproc();
    results();
  end
endmodule
